// ==== fbp_pkg.sv ====
// Purpose: constants for the flash block protection command controller
// Assumes: x8/x16 parallel NOR bus, APB register port at 200 MHz
// Notes: offsets are byte addresses of 32-bit words
package fbp_pkg;
    // apb register offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_RDAT = 8'h10;
    localparam logic [7:0] OFF_PW_LO = 8'h14;
    localparam logic [7:0] OFF_PW_HI = 8'h18;
    // command register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_WORD_BIT = 8;
    // operation codes written by software
    localparam logic [3:0] OP_ENTER = 4'h1;
    localparam logic [3:0] OP_WRITE = 4'h2;
    localparam logic [3:0] OP_READ = 4'h3;
    localparam logic [3:0] OP_EXIT = 4'h4;
    localparam logic [3:0] OP_PW_READ = 4'h5;
    localparam logic [3:0] OP_PW_UNLOCK = 4'h6;
    localparam logic [3:0] OP_CLR_ALL = 4'h7;
    localparam logic [3:0] OP_EXT_EXIT = 4'h8;
    // status fields
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_DONE = 2;
    // flash command codes
    localparam logic [7:0] CODE_UNLK1 = 8'hAA;
    localparam logic [7:0] CODE_UNLK2 = 8'h55;
    localparam logic [7:0] CODE_LOCKREG = 8'h40;
    localparam logic [7:0] CODE_PASSWORD = 8'h60;
    localparam logic [7:0] CODE_NONVOL = 8'hC0;
    localparam logic [7:0] CODE_LOCKBIT = 8'h50;
    localparam logic [7:0] CODE_VOLATILE = 8'hE0;
    localparam logic [7:0] CODE_EXTBLK = 8'h88;
    localparam logic [7:0] CODE_PROGRAM = 8'hA0;
    localparam logic [7:0] CODE_CLR1 = 8'h80;
    localparam logic [7:0] CODE_CLR2 = 8'h30;
    localparam logic [7:0] CODE_PWU1 = 8'h25;
    localparam logic [7:0] CODE_PWU2 = 8'h03;
    localparam logic [7:0] CODE_PWU_END = 8'h29;
    localparam logic [7:0] CODE_EXIT1 = 8'h90;
    localparam logic [7:0] CODE_EXIT2 = 8'h00;
    // unlock addresses
    localparam logic [23:0] ADR_X8_A = 24'h00_0AAA;
    localparam logic [23:0] ADR_X8_B = 24'h00_0555;
    localparam logic [23:0] ADR_X16_A = 24'h00_0555;
    localparam logic [23:0] ADR_X16_B = 24'h00_02AA;
    // password geometry
    localparam int PW_BYTES = 8;
    localparam int PW_WORDS = 4;
    // block status answers
    localparam logic [7:0] BIT_PROTECTED = 8'h00;
    localparam logic [7:0] BIT_UNPROTECTED = 8'h01;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int PWU_GAP_US = 1;
    localparam int PWU_GAP_CYC = PWU_GAP_US * CLK_MHZ;
    localparam int BUS_CYC = 16;
endpackage

// ==== fbp_cycle.sv ====
// Purpose: one asynchronous parallel bus cycle on the flash pins
// Assumes: pins synchronous to pclk
// Notes: write or read of fixed length in clocks
`timescale 1ns/1ps
module fbp_cycle #(
    parameter int CYC = fbp_pkg::BUS_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request
    input wire logic start,
    input wire logic wr,
    input wire logic [23:0] addr,
    input wire logic [15:0] wdata,
    output logic done,
    output logic [15:0] rdata,
    // flash pins
    output logic [23:0] f_addr,
    input wire logic [15:0] f_dq_i,
    output logic [15:0] f_dq_o,
    output logic f_dq_oe,
    output logic f_ce_n,
    output logic f_oe_n,
    output logic f_we_n
);
    logic [7:0] cnt_ff;
    logic act_ff;
    logic wr_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 8'h00;
            act_ff <= 1'b0;
            wr_ff <= 1'b0;
            f_addr <= 24'h00_0000;
            f_dq_o <= 16'h0000;
            f_dq_oe <= 1'b0;
            f_ce_n <= 1'b1;
            f_oe_n <= 1'b1;
            f_we_n <= 1'b1;
            rdata <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!act_ff && start) begin
                act_ff <= 1'b1;
                wr_ff <= wr;
                cnt_ff <= 8'h00;
                f_addr <= addr;
                f_dq_o <= wdata;
                f_dq_oe <= wr;
                f_ce_n <= 1'b0;
            end else if (act_ff) begin
                cnt_ff <= cnt_ff + 8'h01;
                if (cnt_ff == 8'(1)) begin
                    f_we_n <= !wr_ff;
                    f_oe_n <= wr_ff;
                end
                if (cnt_ff == 8'(CYC - 3)) begin
                    f_we_n <= 1'b1;
                    rdata <= f_dq_i;
                end
                if (cnt_ff == 8'(CYC - 2)) begin
                    f_oe_n <= 1'b1;
                    f_ce_n <= 1'b1;
                    f_dq_oe <= 1'b0;
                    act_ff <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== fbp_ctrl.sv ====
// Purpose: host controller issuing block protection command sets to a parallel flash
// Assumes: apb slave at 200 MHz, one flash bus cycle engine
// Notes: software picks the operation, the controller builds the cycle sequence
// Function
// - password read is eight reads at addresses 0 to 7 in x8 mode
// - x8 password unlock is eleven cycles, bytes 2..7 ascending in cycles 5..10
// - x16 password unlock is seven cycles, words 2,3 in cycles 5,6
// - host covers full password over eight byte or four word addresses
// - host keeps one microsecond between unlock commands, device drops closer ones
// - entry is AA, 55, code at AAA/555/AAA x8 or 555/2AA/555 x16
// - password portions may be given in any order if all are covered; the flash model accepts them in ascending address order only
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fbp_ctrl #(
    parameter int PWU_GAP = fbp_pkg::PWU_GAP_CYC,
    parameter int CYC = fbp_pkg::BUS_CYC
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // flash pins
    output logic [23:0] f_addr,
    input wire logic [15:0] f_dq_i,
    output logic [15:0] f_dq_o,
    output logic f_dq_oe,
    output logic f_ce_n,
    output logic f_oe_n,
    output logic f_we_n
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ISSUE = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_GAP = 4'b1000
    } fbp_state_e;

    fbp_state_e state_ff;
    logic [3:0] op_ff;
    logic word_ff;
    logic [7:0] code_ff;
    logic [23:0] addr_ff;
    logic [15:0] data_ff;
    logic [63:0] pw_ff;
    logic [31:0] rdat_ff;
    logic [3:0] step_ff;
    logic refused_ff;
    logic done_ff;
    logic [15:0] gap_ff;
    logic cyc_start;
    logic cyc_wr;
    logic [23:0] cyc_addr;
    logic [15:0] cyc_wdata;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic [3:0] n_steps;
    logic busy;
    logic wr_acc;

    assign busy = (state_ff != ST_IDLE);
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;

    // unlock address of step k of an entry prefix
    function automatic logic [23:0] unlk_addr(input logic wd, input logic [3:0] k);
        if (k == 4'd1) begin
            unlk_addr = wd ? fbp_pkg::ADR_X16_B : fbp_pkg::ADR_X8_B;
        end else begin
            unlk_addr = wd ? fbp_pkg::ADR_X16_A : fbp_pkg::ADR_X8_A;
        end
    endfunction

    // password portion k, byte or word wide
    function automatic logic [15:0] pw_part(input logic [63:0] pw, input logic wd,
                                            input logic [3:0] k);
        if (wd) begin
            pw_part = pw[16*k[1:0] +: 16];
        end else begin
            pw_part = {8'h00, pw[8*k[2:0] +: 8]};
        end
    endfunction

    // number of bus cycles per operation
    always_comb begin
        unique case (op_ff)
            fbp_pkg::OP_ENTER: n_steps = 4'd3;
            fbp_pkg::OP_WRITE: n_steps = 4'd2;
            fbp_pkg::OP_READ: n_steps = 4'd1;
            fbp_pkg::OP_EXIT: n_steps = 4'd2;
            fbp_pkg::OP_PW_READ: n_steps = word_ff ? 4'd4 : 4'd8;
            fbp_pkg::OP_PW_UNLOCK: n_steps = word_ff ? 4'd7 : 4'd11;
            fbp_pkg::OP_CLR_ALL: n_steps = 4'd2;
            fbp_pkg::OP_EXT_EXIT: n_steps = 4'd4;
            default: n_steps = 4'd1;
        endcase
    end

    // cycle content for the current step
    always_comb begin
        cyc_wr = 1'b1;
        cyc_addr = 24'h00_0000;
        cyc_wdata = 16'h0000;
        unique case (op_ff)
            fbp_pkg::OP_ENTER, fbp_pkg::OP_EXT_EXIT: begin
                if (step_ff < 4'd3) begin
                    cyc_addr = unlk_addr(word_ff, step_ff);
                end
                if (step_ff == 4'd0) begin
                    cyc_wdata = {8'h00, fbp_pkg::CODE_UNLK1};
                end else if (step_ff == 4'd1) begin
                    cyc_wdata = {8'h00, fbp_pkg::CODE_UNLK2};
                end else if (op_ff == fbp_pkg::OP_ENTER) begin
                    cyc_wdata = {8'h00, code_ff};
                end else if (step_ff == 4'd2) begin
                    cyc_wdata = {8'h00, fbp_pkg::CODE_EXIT1};
                end else begin
                    cyc_wdata = {8'h00, fbp_pkg::CODE_EXIT2};
                end
            end
            fbp_pkg::OP_WRITE: begin
                if (step_ff == 4'd0) begin
                    cyc_wdata = {8'h00, fbp_pkg::CODE_PROGRAM};
                end else begin
                    cyc_addr = addr_ff;
                    cyc_wdata = data_ff;
                end
            end
            fbp_pkg::OP_READ: begin
                cyc_wr = 1'b0;
                cyc_addr = addr_ff;
            end
            fbp_pkg::OP_EXIT: begin
                cyc_wdata = {8'h00, (step_ff == 4'd0) ? fbp_pkg::CODE_EXIT1
                                                      : fbp_pkg::CODE_EXIT2};
            end
            fbp_pkg::OP_PW_READ: begin
                cyc_wr = 1'b0;
                cyc_addr = {20'h0_0000, step_ff};
            end
            fbp_pkg::OP_PW_UNLOCK: begin
                if (step_ff == 4'd0) begin
                    cyc_wdata = {8'h00, fbp_pkg::CODE_PWU1};
                end else if (step_ff == 4'd1) begin
                    cyc_wdata = {8'h00, fbp_pkg::CODE_PWU2};
                end else if (step_ff == n_steps - 4'd1) begin
                    cyc_wdata = {8'h00, fbp_pkg::CODE_PWU_END};
                end else begin
                    cyc_addr = {20'h0_0000, step_ff - 4'd2};
                    cyc_wdata = pw_part(pw_ff, word_ff, step_ff - 4'd2);
                end
            end
            fbp_pkg::OP_CLR_ALL: begin
                cyc_wdata = {8'h00, (step_ff == 4'd0) ? fbp_pkg::CODE_CLR1
                                                      : fbp_pkg::CODE_CLR2};
            end
            default: begin
                cyc_wr = 1'b1;
            end
        endcase
    end

    assign cyc_start = (state_ff == ST_ISSUE);

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            step_ff <= 4'd0;
            gap_ff <= 16'h0000;
            refused_ff <= 1'b0;
            done_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            if (gap_ff != 16'h0000) begin
                gap_ff <= gap_ff - 16'h0001;
            end
            unique case (state_ff)
                ST_IDLE: begin
                    if (wr_acc && paddr == fbp_pkg::OFF_CMD) begin
                        if (pwdata[3:0] == fbp_pkg::OP_PW_UNLOCK && gap_ff != 16'h0000) begin
                            refused_ff <= 1'b1;
                        end else begin
                            state_ff <= ST_ISSUE;
                            step_ff <= 4'd0;
                            done_ff <= 1'b0;
                            refused_ff <= 1'b0;
                        end
                    end
                end
                ST_ISSUE: begin
                    state_ff <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (cyc_done) begin
                        if (!cyc_wr) begin
                            rdat_ff <= {16'h0000, cyc_rdata};
                        end
                        if (step_ff == n_steps - 4'd1) begin
                            state_ff <= ST_GAP;
                        end else begin
                            step_ff <= step_ff + 4'd1;
                            state_ff <= ST_ISSUE;
                        end
                    end
                end
                ST_GAP: begin
                    if (op_ff == fbp_pkg::OP_PW_UNLOCK) begin
                        gap_ff <= 16'(PWU_GAP);
                    end
                    state_ff <= ST_IDLE;
                    done_ff <= 1'b1;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_ff <= 4'h0;
            word_ff <= 1'b0;
            code_ff <= 8'h00;
            addr_ff <= 24'h00_0000;
            data_ff <= 16'h0000;
            pw_ff <= 64'hFFFF_FFFF_FFFF_FFFF;
        end else if (wr_acc && !busy) begin
            unique case (paddr)
                fbp_pkg::OFF_CMD: begin
                    op_ff <= pwdata[3:0];
                    word_ff <= pwdata[fbp_pkg::CMD_WORD_BIT];
                    code_ff <= pwdata[23:16];
                end
                fbp_pkg::OFF_ADDR: addr_ff <= pwdata[23:0];
                fbp_pkg::OFF_DATA: data_ff <= pwdata[15:0];
                fbp_pkg::OFF_PW_LO: pw_ff[31:0] <= pwdata;
                fbp_pkg::OFF_PW_HI: pw_ff[63:32] <= pwdata;
                default: op_ff <= op_ff;
            endcase
        end
    end

    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            fbp_pkg::OFF_CMD: prdata = {8'h00, code_ff, 7'h00, word_ff, 4'h0, op_ff};
            fbp_pkg::OFF_ADDR: prdata = {8'h00, addr_ff};
            fbp_pkg::OFF_DATA: prdata = {16'h0000, data_ff};
            fbp_pkg::OFF_STAT: prdata = {29'h0, done_ff, refused_ff, busy};
            fbp_pkg::OFF_RDAT: prdata = rdat_ff;
            fbp_pkg::OFF_PW_LO: prdata = pw_ff[31:0];
            fbp_pkg::OFF_PW_HI: prdata = pw_ff[63:32];
            default: pslverr = psel && penable;
        endcase
    end

    fbp_cycle #(.CYC(CYC)) u_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .start(cyc_start),
        .wr(cyc_wr),
        .addr(cyc_addr),
        .wdata(cyc_wdata),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .f_addr(f_addr),
        .f_dq_i(f_dq_i),
        .f_dq_o(f_dq_o),
        .f_dq_oe(f_dq_oe),
        .f_ce_n(f_ce_n),
        .f_oe_n(f_oe_n),
        .f_we_n(f_we_n)
    );

    // assertions
    property p_enter_first;
        @(posedge pclk) disable iff (!presetn)
        (cyc_start && op_ff == fbp_pkg::OP_ENTER && step_ff == 4'd0)
            |-> cyc_wdata[7:0] == fbp_pkg::CODE_UNLK1;
    endproperty
    a_enter_first: assert property (p_enter_first) else $error("entry not AA");

    property p_pw_steps;
        @(posedge pclk) disable iff (!presetn)
        (op_ff == fbp_pkg::OP_PW_UNLOCK) |-> n_steps == (word_ff ? 4'd7 : 4'd11);
    endproperty
    a_pw_steps: assert property (p_pw_steps) else $error("unlock length wrong");

    property p_gap;
        @(posedge pclk) disable iff (!presetn)
        (state_ff == ST_GAP && op_ff == fbp_pkg::OP_PW_UNLOCK) |=> gap_ff == 16'(PWU_GAP);
    endproperty
    a_gap: assert property (p_gap) else $error("unlock gap not armed");

    property p_pwread;
        @(posedge pclk) disable iff (!presetn)
        (cyc_start && op_ff == fbp_pkg::OP_PW_READ) |-> !cyc_wr && cyc_addr[3:0] == step_ff;
    endproperty
    a_pwread: assert property (p_pwread) else $error("password read address");

    property p_exit;
        @(posedge pclk) disable iff (!presetn)
        (cyc_start && op_ff == fbp_pkg::OP_EXIT && step_ff == 4'd1)
            |-> cyc_wdata[7:0] == fbp_pkg::CODE_EXIT2;
    endproperty
    a_exit: assert property (p_exit) else $error("exit second code");

    property p_ext_exit;
        @(posedge pclk) disable iff (!presetn)
        (cyc_start && op_ff == fbp_pkg::OP_EXT_EXIT && step_ff == 4'd2)
            |-> cyc_wdata[7:0] == fbp_pkg::CODE_EXIT1;
    endproperty
    a_ext_exit: assert property (p_ext_exit) else $error("extended exit third code");

    property p_dq_oe;
        @(posedge pclk) disable iff (!presetn)
        f_dq_oe |-> f_oe_n;
    endproperty
    a_dq_oe: assert property (p_dq_oe) else $error("data bus driven during read");

    c_unlock: cover property (@(posedge pclk) state_ff == ST_GAP && op_ff == fbp_pkg::OP_PW_UNLOCK);
    c_refused: cover property (@(posedge pclk) $rose(refused_ff));
    c_read: cover property (@(posedge pclk) state_ff == ST_GAP && op_ff == fbp_pkg::OP_READ);
endmodule

// ==== fbp_flash_model.sv ====
// Purpose: behavioural x8 flash device answering the protection command sets
// Assumes: a write is taken at the rise of we_n while ce_n is low
// Notes: main array reads give address xor 5a, released data bus shows inverse
`timescale 1ns/1ps
module fbp_flash_model #(
    parameter int GAP_NS = 100,
    parameter int UNL_NS = 1000,
    parameter bit PW_MODE_LOCKED = 1'b0
) (
    // flash pins
    input wire logic [23:0] f_addr,
    output logic [15:0] f_dq_i,
    input wire logic [15:0] f_dq_o,
    input wire logic f_ce_n,
    input wire logic f_oe_n,
    input wire logic f_we_n
);
    logic [7:0] mode = 8'h00;
    logic [7:0] pend = 8'h00;
    logic [7:0] nxt = 8'h00;
    logic [7:0] lockreg = 8'hFF;
    logic [7:0] held = 8'h00;
    logic [7:0] rd;
    logic [7:0] pw [8] = '{default: 8'hFF};
    logic [7:0] got [8] = '{default: 8'h00};
    logic [7:0] ext [256] = '{default: 8'hFF};
    logic [3:0] nv = 4'hF;
    logic [3:0] vol = 4'hF;
    logic lock = 1'b1;
    int unl = 0;
    int pcnt = 0;
    realtime last_unl = -1.0e6;
    wire [1:0] blk = f_addr[17:16];
    wire [7:0] d = f_dq_o[7:0];
    always_comb begin
        case (mode)
            8'h40: rd = lockreg;
            8'h60: rd = PW_MODE_LOCKED ? 8'hFF : pw[f_addr[2:0]];
            8'hC0: rd = {7'h00, nv[blk]};
            8'h50: rd = {7'h00, lock};
            8'hE0: rd = {7'h00, vol[blk]};
            8'h88: rd = ext[f_addr[7:0]];
            default: rd = f_addr[7:0] ^ 8'h5A;
        endcase
    end
    assign f_dq_i = (!f_ce_n && !f_oe_n) ? {8'h00, rd} : {8'hFF, ~held};
    always @(posedge f_oe_n) held <= rd;
    task automatic prog();
        case (mode)
            8'h40: lockreg = lockreg & d;
            8'h60: pw[f_addr[2:0]] = d;
            8'hC0: if (lock) nv[blk] = 1'b0;
            8'h50: lock = 1'b0;
            8'hE0: vol[blk] = d[0];
            8'h88: if (lockreg[0]) ext[f_addr[7:0]] = ext[f_addr[7:0]] & d;
            default: ;
        endcase
    endtask
    always @(posedge f_we_n) begin
        if (!f_ce_n) begin
            nxt = 8'h00;
            case (pend)
                8'hA0: prog();
                8'h80: if (d == 8'h30 && lock) begin
                    nv = 4'h0;
                    nv = 4'hF;
                end
                8'h90: if (d == 8'h00) mode = 8'h00;
                8'h25: if (d == 8'h03) begin
                    nxt = 8'h03;
                    pcnt = 0;
                end
                8'h03: if (pcnt < 8 && f_addr[2:0] == pcnt[2:0]) begin
                    got[pcnt] = d;
                    pcnt++;
                    nxt = 8'h03;
                end else if (pcnt == 8 && d == 8'h29 && $realtime - last_unl >= GAP_NS) begin
                    last_unl = $realtime;
                    if (got == pw) fork
                        #(UNL_NS) lock = 1'b1;
                    join_none
                end
                default: begin
                    if (unl == 2 && f_addr == 24'h00_0AAA && d != 8'h90) mode = d;
                    else if (d inside {8'hA0, 8'h80, 8'h90, 8'h25}) nxt = d;
                    unl = (d == 8'hAA && f_addr == 24'h00_0AAA) ? 1 :
                        (unl == 1 && d == 8'h55 && f_addr == 24'h00_0555) ? 2 : 0;
                end
            endcase
            pend = nxt;
        end
    end
endmodule

// ==== tb.sv ====
// Purpose: self-checking bench for the protection command controller
// Assumes: x8 device model on the flash pins, shortened unlock gap
// Notes: all requests go through the apb registers
`timescale 1ns/1ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, f_dq_oe, f_ce_n, f_oe_n, f_we_n;
    logic [23:0] f_addr;
    logic [15:0] f_dq_i, f_dq_o;
    int fails = 0;
    int tests_run = 0;
    fbp_ctrl #(.PWU_GAP(20)) fbp_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .f_addr(f_addr), .f_dq_i(f_dq_i),
        .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n));
    fbp_flash_model fbp_flash_model_inst (.f_addr(f_addr), .f_dq_i(f_dq_i), .f_dq_o(f_dq_o),
        .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n));
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic op(input logic [3:0] o, input logic [7:0] c = 8'h00,
                      input logic [23:0] a = 24'h00_0000, input logic [15:0] dd = 16'h0000);
        apb(1'b1, fbp_pkg::OFF_ADDR, {8'h00, a});
        apb(1'b1, fbp_pkg::OFF_DATA, {16'h0000, dd});
        apb(1'b1, fbp_pkg::OFF_CMD, {8'h00, c, 12'h000, o});
        do
            apb(1'b0, fbp_pkg::OFF_STAT, 32'h0000_0000);
        while (q[fbp_pkg::ST_BUSY] !== 1'b0);
    endtask
    task automatic rdat(input string n, input logic [7:0] x);
        apb(1'b0, fbp_pkg::OFF_RDAT, 32'h0000_0000);
        chk(n, {24'h00_0000, x}, {24'h00_0000, q[7:0]});
    endtask
    task automatic rdchk(input string n, input logic [23:0] a, input logic [7:0] x);
        op(fbp_pkg::OP_READ, 8'h00, a);
        rdat(n, x);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, fbp_pkg::OFF_STAT, 32'h0000_0000);
        chk("status after reset", 32'h0000_0000, q);
        apb(1'b0, fbp_pkg::OFF_PW_LO, 32'h0000_0000);
        chk("password low after reset", 32'hFFFF_FFFF, q);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_PASSWORD);
        op(fbp_pkg::OP_PW_READ);
        rdat("blank password byte", 8'hFF);
        op(fbp_pkg::OP_WRITE, 8'h00, 24'h00_0003, 16'h003C);
        op(fbp_pkg::OP_WRITE, 8'h00, 24'h00_0007, 16'h005A);
        rdchk("password byte 3", 24'h00_0003, 8'h3C);
        op(fbp_pkg::OP_PW_READ);
        rdat("password byte 7", 8'h5A);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_NONVOL);
        rdchk("nv bit fresh", 24'h01_0000, 8'h01);
        op(fbp_pkg::OP_WRITE, 8'h00, 24'h01_0000);
        rdchk("nv bit set", 24'h01_0000, 8'h00);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_LOCKBIT);
        op(fbp_pkg::OP_WRITE);
        rdchk("lock bit set", 24'h00_0000, 8'h00);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_NONVOL);
        op(fbp_pkg::OP_CLR_ALL);
        rdchk("clear all while locked", 24'h01_0000, 8'h00);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_PASSWORD);
        op(fbp_pkg::OP_PW_UNLOCK);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_LOCKBIT);
        rdchk("lock after wrong password", 24'h00_0000, 8'h00);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_PASSWORD);
        apb(1'b1, fbp_pkg::OFF_PW_LO, 32'h3CFF_FFFF);
        apb(1'b1, fbp_pkg::OFF_PW_HI, 32'h5AFF_FFFF);
        op(fbp_pkg::OP_PW_UNLOCK);
        chk("unlock run", 32'h0000_0000, {31'h0000_0000, q[fbp_pkg::ST_REFUSED]});
        op(fbp_pkg::OP_PW_UNLOCK);
        chk("unlock too soon", 32'h0000_0001, {31'h0000_0000, q[fbp_pkg::ST_REFUSED]});
        repeat (200) @(posedge pclk);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_LOCKBIT);
        rdchk("lock after unlock", 24'h00_0000, 8'h01);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_NONVOL);
        op(fbp_pkg::OP_CLR_ALL);
        rdchk("clear all unlocked", 24'h01_0000, 8'h01);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_VOLATILE);
        rdchk("volatile after reset", 24'h02_0000, 8'h01);
        op(fbp_pkg::OP_WRITE, 8'h00, 24'h02_0000, 16'h0000);
        rdchk("volatile set", 24'h02_0000, 8'h00);
        op(fbp_pkg::OP_WRITE, 8'h00, 24'h02_0000, 16'h0001);
        rdchk("volatile cleared", 24'h02_0000, 8'h01);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_EXTBLK);
        op(fbp_pkg::OP_WRITE, 8'h00, 24'h00_0005, 16'h0077);
        rdchk("extended block", 24'h00_0005, 8'h77);
        op(fbp_pkg::OP_EXT_EXIT);
        rdchk("main array after exit", 24'h00_0005, 8'h5F);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_LOCKREG);
        op(fbp_pkg::OP_WRITE, 8'h00, 24'h00_0000, 16'h00FE);
        rdchk("lock register", 24'h00_0000, 8'hFE);
        op(fbp_pkg::OP_EXIT);
        op(fbp_pkg::OP_ENTER, fbp_pkg::CODE_EXTBLK);
        op(fbp_pkg::OP_WRITE, 8'h00, 24'h00_0006, 16'h0011);
        rdchk("frozen extended block", 24'h00_0006, 8'hFF);
        op(fbp_pkg::OP_EXT_EXIT);
        tally_and_finish();
    end
endmodule
